/* slq_defines.svh */
// Register offsets, field positions, reset values and rate limits of the link configuration block.
`ifndef SLQ_DEFINES_SVH
`define SLQ_DEFINES_SVH

`define SLQ_ADDR_W 12
`define SLQ_DATA_W 8
`define SLQ_OFF_LANE_RATE 12'h56E
`define SLQ_OFF_QUICK_CFG 12'h570
`define SLQ_OFF_LINK_PWR 12'h5A0
`define SLQ_OFF_FRAME_K 12'h5A1
`define SLQ_OFF_LINK_STAT 12'h5A2
`define SLQ_BIT_LOW_RATE 4
`define SLQ_BIT_PWR_DOWN 0
`define SLQ_BIT_STAT_UP 0
`define SLQ_BIT_STAT_VALID 1
`define SLQ_BIT_STAT_LOW 2
`define SLQ_RST_LANE_RATE 8'h00
`define SLQ_RST_QUICK_CFG 8'h01
`define SLQ_RST_LINK_PWR 8'h01
`define SLQ_RST_FRAME_K 8'h20
`define SLQ_LOW_RATE_VAL 8'h10
`define SLQ_NPRIME 16
`define SLQ_RATE_MIN_MBPS 24'd3125
`define SLQ_RATE_LOW_MBPS 24'd6250
`define SLQ_RATE_MAX_MBPS 24'd12500
`define SLQ_K_MAX 8'd32

`define SLQ_HOFF_CMD 4'h0
`define SLQ_HOFF_QC 4'h1
`define SLQ_HOFF_FOUT_LO 4'h2
`define SLQ_HOFF_FOUT_HI 4'h3
`define SLQ_HOFF_K 4'h4
`define SLQ_HOFF_STAT 4'h5
`define SLQ_HOFF_RATE_LO 4'h6
`define SLQ_HOFF_RATE_MI 4'h7
`define SLQ_HOFF_RATE_HI 4'h8

`endif

/* slq_pkg.sv */
// Types and shared decode functions of the link configuration block.
package slq_pkg;
`include "slq_defines.svh"

    typedef struct packed {
        logic valid;
        logic [3:0] lanes;
        logic [3:0] convs;
        logic [4:0] octets;
        logic [3:0] samples;
        logic hd;
    } slq_link_s;

    // Maps a quick configuration code to its transport settings.
    function automatic slq_link_s slqDecode(input logic [7:0] code);
        slq_link_s d;
        d = '0;
        d.valid = 1'b1;
        unique case (code)
            8'h01: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h1, 4'h1, 5'h02, 4'h1, 1'b0};
            8'h40: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h2, 4'h1, 5'h01, 4'h1, 1'b1};
            8'h41: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h2, 4'h1, 5'h02, 4'h2, 1'b0};
            8'h80: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h1, 5'h01, 4'h2, 1'b1};
            8'h81: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h1, 5'h02, 4'h4, 1'b0};
            8'hC0: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h1, 5'h01, 4'h4, 1'b1};
            8'hC1: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h1, 5'h02, 4'h8, 1'b0};
            8'h0A: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h1, 4'h2, 5'h04, 4'h1, 1'b0};
            8'h49: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h2, 4'h2, 5'h02, 4'h1, 1'b0};
            8'h88: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h2, 5'h01, 4'h1, 1'b1};
            8'h89: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h2, 5'h02, 4'h2, 1'b0};
            8'hC8: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h2, 5'h01, 4'h2, 1'b1};
            8'hC9: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h2, 5'h02, 4'h4, 1'b0};
            8'h13: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h1, 4'h4, 5'h08, 4'h1, 1'b0};
            8'h52: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h2, 4'h4, 5'h04, 4'h1, 1'b0};
            8'h91: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h4, 5'h02, 4'h1, 1'b0};
            8'hD0: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h4, 5'h01, 4'h1, 1'b1};
            8'hD1: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h4, 5'h02, 4'h2, 1'b0};
            8'h1C: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h1, 4'h8, 5'h10, 4'h1, 1'b0};
            8'h5B: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h2, 4'h8, 5'h08, 4'h1, 1'b0};
            8'h9A: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h4, 4'h8, 5'h04, 4'h1, 1'b0};
            8'hD9: {d.lanes, d.convs, d.octets, d.samples, d.hd} = {4'h8, 4'h8, 5'h02, 4'h1, 1'b0};
            default: d.valid = 1'b0;
        endcase
        return d;
    endfunction

    // Lane rate in Mbps: M * N' * 10/8 * fout / L, with L a power of two.
    function automatic logic [23:0] slqLaneRate(input slq_link_s d, input logic [15:0] foutMhz);
        logic [27:0] prod;
        logic [1:0] sh;
        prod = 28'(d.convs) * 28'((`SLQ_NPRIME * 10) / 8) * 28'(foutMhz);
        sh = d.lanes[3] ? 2'd3 : (d.lanes[2] ? 2'd2 : (d.lanes[1] ? 2'd1 : 2'd0));
        prod = prod >> sh;
        return (prod[27:24] != 4'h0) ? 24'hFFFFFF : prod[23:0];
    endfunction
endpackage

/* slq_cfg_if.sv */
// Configuration port between the configuring party and the link device.
`timescale 1ns/1ps
interface slq_cfg_if;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;

    modport host (output addr, output wdata, output wr, output rd, input rdata);
    modport device (input addr, input wdata, input wr, input rd, output rdata);
endinterface

/* slq_link_device.sv */
// Link device end: configuration registers, quick configuration decode and link power control.
//
// Functional notes
// - All enabled lanes form one single link.
// - Quick configuration register sets L, M, F.
// - Software computes lane rate from M, N', L.
// - Chosen lane rate stays within supported range.
// - Power down, configure, then power up.
// - Below threshold, low rate mode is enabled.
// - At or above threshold, low rate cleared.
// - Each code maps to fixed L,M,F,S,HD.
// - K chosen from allowed list per F.
// - L, M, F together set link setup.
`timescale 1ns/1ps
module slq_link_device
    import slq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    slq_cfg_if.device cfg,
    output logic linkUp,
    output logic [7:0] serialLaneEnable,
    output logic [3:0] laneCount,
    output logic [3:0] convCount,
    output logic [4:0] octetsPerFrame,
    output logic [3:0] samplesPerConv,
    output logic highDensity,
    output logic [7:0] frameK,
    output logic lowRateMode
);
`include "slq_defines.svh"

    logic [7:0] laneRate_r;
    logic [7:0] quickCfg_r;
    logic [7:0] linkPwr_r;
    logic [7:0] frameK_r;
    logic [7:0] rdata_r;
    logic linkUp_r;
    logic appliedValid_r;
    logic [7:0] laneEn_r;
    logic [3:0] laneCount_r;
    logic [3:0] convCount_r;
    logic [4:0] octets_r;
    logic [3:0] samples_r;
    logic hd_r;
    logic [7:0] frameKOut_r;
    logic lowRate_r;
    slq_link_s dec;
    logic pwrDown;
    logic tryApply;
    logic applyNow;

    // True when the bus writes the register at the given offset in this cycle.
    // Every writable register uses it, so the address compare lives in one place.
    function automatic logic wrHit(input logic wr, input logic [11:0] addr, input logic [11:0] offset);
        return wr && (addr == offset);
    endfunction

    // Quick configuration decode of the stored code.
    // code selects parameters
    assign dec = slqDecode(quickCfg_r);

    // Power state, and the cycles in which a stored setup may be applied.
    assign pwrDown = linkPwr_r[`SLQ_BIT_PWR_DOWN];
    assign tryApply = !pwrDown && !linkUp_r;
    assign applyNow = tryApply && dec.valid;

    // Lane-rate control register; its low-rate bit reaches the serializer only at power-up.
    // Software sets that bit for slow lanes and clears it for fast ones.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            laneRate_r <= `SLQ_RST_LANE_RATE;
        end else if (wrHit(cfg.wr, cfg.addr, `SLQ_OFF_LANE_RATE)) begin
            laneRate_r <= cfg.wdata;
        end
    end

    // Quick configuration code; a change while the link is up waits for the next power cycle.
    // code written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quickCfg_r <= `SLQ_RST_QUICK_CFG;
        end else if (wrHit(cfg.wr, cfg.addr, `SLQ_OFF_QUICK_CFG)) begin
            quickCfg_r <= cfg.wdata;
        end
    end

    // Link power register; only the power-down bit is kept, the other bits read as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            linkPwr_r <= `SLQ_RST_LINK_PWR;
        end else if (wrHit(cfg.wr, cfg.addr, `SLQ_OFF_LINK_PWR)) begin
            linkPwr_r <= {7'h00, cfg.wdata[`SLQ_BIT_PWR_DOWN]};
        end
    end

    // Requested K; the frame logic sees it only after the next power-up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frameK_r <= `SLQ_RST_FRAME_K;
        end else if (wrHit(cfg.wr, cfg.addr, `SLQ_OFF_FRAME_K)) begin
            frameK_r <= cfg.wdata;
        end
    end

    // Read data, valid in the cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (cfg.rd) begin
            unique case (cfg.addr)
                `SLQ_OFF_LANE_RATE: rdata_r <= laneRate_r;
                `SLQ_OFF_QUICK_CFG: rdata_r <= quickCfg_r;
                `SLQ_OFF_LINK_PWR: rdata_r <= linkPwr_r;
                `SLQ_OFF_FRAME_K: rdata_r <= frameK_r;
                `SLQ_OFF_LINK_STAT: rdata_r <= {5'h00, lowRate_r, appliedValid_r, linkUp_r};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Link state: falls one edge after the power-down bit is stored, rises when a known code is applied.
    // An unknown code leaves the link down and is tried again every cycle until software replaces it.
    // idle while down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            linkUp_r <= 1'b0;
        end else if (pwrDown) begin
            linkUp_r <= 1'b0;
        end else if (applyNow) begin
            linkUp_r <= 1'b1;
        end
    end

    // Records whether the code tried at the last power-up attempt was a known one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            appliedValid_r <= 1'b0;
        end else if (tryApply) begin
            appliedValid_r <= dec.valid;
        end
    end

    // Transport settings, frozen while the link is up so the far end never sees them move.
    // L M F set link
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            laneCount_r <= 4'h0;
            convCount_r <= 4'h0;
            octets_r <= 5'h00;
            samples_r <= 4'h0;
            hd_r <= 1'b0;
        end else if (applyNow) begin
            laneCount_r <= dec.lanes;
            convCount_r <= dec.convs;
            octets_r <= dec.octets;
            samples_r <= dec.samples;
            hd_r <= dec.hd;
        end
    end

    // Applied K, taken in the same cycle as the transport settings; the configuring party keeps it legal.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frameKOut_r <= 8'h00;
        end else if (applyNow) begin
            frameKOut_r <= frameK_r;
        end
    end

    // Serializer rate mode, taken at power-up alongside the transport settings.
    // low rate serializer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowRate_r <= 1'b0;
        end else if (applyNow) begin
            lowRate_r <= laneRate_r[`SLQ_BIT_LOW_RATE];
        end
    end

    // Lane enables: the lowest L lanes all carry the one link, or none at all.
    // single link
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            laneEn_r <= 8'h00;
        end else if (pwrDown || !linkUp_r) begin
            laneEn_r <= 8'h00;
        end else begin
            laneEn_r <= 8'((9'h001 << laneCount_r) - 9'h001);
        end
    end

    assign cfg.rdata = rdata_r;
    assign linkUp = linkUp_r;
    assign serialLaneEnable = laneEn_r;
    assign laneCount = laneCount_r;
    assign convCount = convCount_r;
    assign octetsPerFrame = octets_r;
    assign samplesPerConv = samples_r;
    assign highDensity = hd_r;
    assign frameK = frameKOut_r;
    assign lowRateMode = lowRate_r;
endmodule

/* slq_link_host.sv */
// Configuring party: checks a requested setup and programs the link device in order.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module slq_link_host
    import slq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    slq_cfg_if.host cfg,
    input wire logic [3:0] userAddr,
    input wire logic [7:0] userWdata,
    input wire logic userWr,
    input wire logic userRd,
    output logic [7:0] userRdata
);
`include "slq_defines.svh"

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_PDN = 9'h002,
        ST_QC = 9'h004,
        ST_LR = 9'h008,
        ST_K = 9'h010,
        ST_PUP = 9'h020,
        ST_WAIT = 9'h040,
        ST_RD = 9'h080,
        ST_CHK = 9'h100
    } slq_state_e;

    slq_state_e state_r;
    logic [7:0] qc_r;
    logic [15:0] fout_r;
    logic [7:0] k_r;
    logic busy_r, done_r, errRate_r, errK_r, linkOk_r;
    logic [11:0] addr_r;
    logic [7:0] wdata_r, userRdata_r;
    logic wr_r, rd_r;
    slq_link_s dec;
    logic [23:0] rate;
    logic rateOk, kOk, lowNeeded, start;

    assign dec = slqDecode(qc_r);
    assign rate = slqLaneRate(dec, fout_r);
    assign rateOk = dec.valid && rate >= `SLQ_RATE_MIN_MBPS && rate <= `SLQ_RATE_MAX_MBPS;
    assign lowNeeded = rate < `SLQ_RATE_LOW_MBPS;
    assign kOk = (k_r[1:0] == 2'b00) && k_r <= `SLQ_K_MAX &&
                 ((dec.octets == 5'h01) ? k_r >= 8'd20 :
                  (dec.octets == 5'h02) ? k_r >= 8'd12 :
                  (dec.octets == 5'h04) ? k_r >= 8'd8 : k_r >= 8'd4);
    assign start = userWr && userAddr == `SLQ_HOFF_CMD && userWdata[0] && state_r == ST_IDLE;

    // User-side settings registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qc_r <= `SLQ_RST_QUICK_CFG;
            fout_r <= 16'h0000;
            k_r <= `SLQ_RST_FRAME_K;
        end else if (userWr && state_r == ST_IDLE) begin
            unique case (userAddr)
                `SLQ_HOFF_QC: qc_r <= userWdata;
                `SLQ_HOFF_FOUT_LO: fout_r[7:0] <= userWdata;
                `SLQ_HOFF_FOUT_HI: fout_r[15:8] <= userWdata;
                `SLQ_HOFF_K: k_r <= userWdata;
                default: ;
            endcase
        end
    end

    // Sequence: power down, quick config, lane rate, K, power up, wait, then confirm.
    // The link rises two edges after the power-up write, so the status read waits one cycle.
    // ordered configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 12'h000;
            wdata_r <= 8'h00;
        end else begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: if (start && rateOk && kOk) begin
                    state_r <= ST_PDN;
                    wr_r <= 1'b1;
                    addr_r <= `SLQ_OFF_LINK_PWR;
                    wdata_r <= 8'h01;
                end
                ST_PDN: begin
                    state_r <= ST_QC;
                    wr_r <= 1'b1;
                    addr_r <= `SLQ_OFF_QUICK_CFG;
                    wdata_r <= qc_r;
                end
                ST_QC: begin
                    state_r <= ST_LR;
                    wr_r <= 1'b1;
                    addr_r <= `SLQ_OFF_LANE_RATE;
                    wdata_r <= lowNeeded ? `SLQ_LOW_RATE_VAL : 8'h00;
                end
                ST_LR: begin
                    state_r <= ST_K;
                    wr_r <= 1'b1;
                    addr_r <= `SLQ_OFF_FRAME_K;
                    wdata_r <= k_r;
                end
                ST_K: begin
                    state_r <= ST_PUP;
                    wr_r <= 1'b1;
                    addr_r <= `SLQ_OFF_LINK_PWR;
                    wdata_r <= 8'h00;
                end
                ST_PUP: state_r <= ST_WAIT;
                ST_WAIT: begin
                    state_r <= ST_RD;
                    rd_r <= 1'b1;
                    addr_r <= `SLQ_OFF_LINK_STAT;
                end
                ST_RD: state_r <= ST_CHK;
                ST_CHK: state_r <= ST_IDLE;
            endcase
        end
    end

    // Status flags; a new start clears the previous outcome.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            errRate_r <= 1'b0;
            errK_r <= 1'b0;
            linkOk_r <= 1'b0;
        end else if (start) begin
            busy_r <= rateOk && kOk;
            done_r <= !(rateOk && kOk);
            errRate_r <= !rateOk;
            errK_r <= !kOk;
            linkOk_r <= 1'b0;
        end else if (state_r == ST_CHK) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            linkOk_r <= cfg.rdata[`SLQ_BIT_STAT_UP];
        end
    end

    // User read data, one cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            userRdata_r <= 8'h00;
        end else if (userRd) begin
            unique case (userAddr)
                `SLQ_HOFF_QC: userRdata_r <= qc_r;
                `SLQ_HOFF_FOUT_LO: userRdata_r <= fout_r[7:0];
                `SLQ_HOFF_FOUT_HI: userRdata_r <= fout_r[15:8];
                `SLQ_HOFF_K: userRdata_r <= k_r;
                `SLQ_HOFF_STAT: userRdata_r <= {2'b00, lowNeeded, linkOk_r, errK_r, errRate_r, done_r, busy_r};
                `SLQ_HOFF_RATE_LO: userRdata_r <= rate[7:0];
                `SLQ_HOFF_RATE_MI: userRdata_r <= rate[15:8];
                `SLQ_HOFF_RATE_HI: userRdata_r <= rate[23:16];
                default: userRdata_r <= 8'h00;
            endcase
        end else begin
            userRdata_r <= 8'h00;
        end
    end

    assign cfg.addr = addr_r;
    assign cfg.wdata = wdata_r;
    assign cfg.wr = wr_r;
    assign cfg.rd = rd_r;
    assign userRdata = userRdata_r;
endmodule

/* slq_link_sva.sv */
// Checker for the configuration port and lane outputs of the link configuration block.
`timescale 1ns/1ps
module slq_link_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic linkUp,
    input wire logic [7:0] serialLaneEnable,
    input wire logic [3:0] laneCount
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Builds the lane mask that one link of the given width occupies.
    function automatic logic [7:0] laneMask(input logic [3:0] lanes);
        return 8'((9'h001 << lanes) - 9'h001);
    endfunction

    property p_no_both;
        !(wr && rd);
    endproperty
    a_no_both: assert property (p_no_both) else $error("write and read strobes together");
    property p_rd_pulse;
        rd |=> !rd;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe longer than one cycle");
    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
    property p_status_read;
        rd && addr == 12'h5A2 |=> rdata[7:3] == 5'h00 && rdata[0] == $past(linkUp);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read does not show link state");
    property p_down_delay;
        wr && addr == 12'h5A0 && wdata[0] |-> ##2 !linkUp;
    endproperty
    a_down_delay: assert property (p_down_delay) else $error("link still up after power-down");
    property p_up_cause;
        $rose(linkUp) |-> $past(wr, 2) && $past(addr, 2) == 12'h5A0 && ($past(wdata, 2) & 8'h01) == 8'h00;
    endproperty
    a_up_cause: assert property (p_up_cause) else $error("link rose without a power-up write");
    property p_lanes_off;
        !linkUp |=> serialLaneEnable == 8'h00;
    endproperty
    a_lanes_off: assert property (p_lanes_off) else $error("lanes active while link down");
    property p_lane_mask;
        linkUp ##1 linkUp |-> serialLaneEnable == laneMask(laneCount);
    endproperty
    a_lane_mask: assert property (p_lane_mask) else $error("lanes do not form one link of L lanes");
    property p_lane_stable;
        linkUp ##1 linkUp |-> $stable(laneCount);
    endproperty
    a_lane_stable: assert property (p_lane_stable) else $error("lane count changed while up");
    property p_status_after_up;
        rd && addr == 12'h5A2 |-> linkUp;
    endproperty
    a_status_after_up: assert property (p_status_after_up) else $error("status read before link is up");

    c_link_up: cover property ($rose(linkUp));
    c_link_down: cover property ($fell(linkUp));
    c_status: cover property (rd && addr == 12'h5A2);
endmodule

/* testbench.sv */
// Self-checking bench joining the host and device ends of the link configuration block.
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst_n;
    logic [3:0] userAddr = 4'h0;
    logic [7:0] userWdata = 8'h00;
    logic userWr = 1'b0;
    logic userRd = 1'b0;
    logic [7:0] userRdata;
    logic linkUp;
    logic [7:0] serialLaneEnable;
    logic [3:0] laneCount;
    logic [3:0] convCount;
    logic [4:0] octetsPerFrame;
    logic [3:0] samplesPerConv;
    logic highDensity;
    logic [7:0] frameK;
    logic lowRateMode;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    slq_cfg_if u_slq_cfg_if ();
    slq_link_device u_slq_link_device (.clk(clk), .rst_n(rst_n), .cfg(u_slq_cfg_if.device), .linkUp(linkUp),
        .serialLaneEnable(serialLaneEnable), .laneCount(laneCount), .convCount(convCount),
        .octetsPerFrame(octetsPerFrame), .samplesPerConv(samplesPerConv), .highDensity(highDensity),
        .frameK(frameK), .lowRateMode(lowRateMode));
    slq_link_host u_slq_link_host (.clk(clk), .rst_n(rst_n), .cfg(u_slq_cfg_if.host), .userAddr(userAddr),
        .userWdata(userWdata), .userWr(userWr), .userRd(userRd), .userRdata(userRdata));
    slq_link_sva u_slq_link_sva (.clk(clk), .rst_n(rst_n), .addr(u_slq_cfg_if.addr), .wdata(u_slq_cfg_if.wdata),
        .wr(u_slq_cfg_if.wr), .rd(u_slq_cfg_if.rd), .rdata(u_slq_cfg_if.rdata), .linkUp(linkUp),
        .serialLaneEnable(serialLaneEnable), .laneCount(laneCount));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cuts a hang short after a generous cycle ceiling.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask

    task automatic uwr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        userAddr <= a;
        userWdata <= d;
        userWr <= 1'b1;
        @(posedge clk);
        userWr <= 1'b0;
    endtask

    task automatic urd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        userAddr <= a;
        userRd <= 1'b1;
        @(posedge clk);
        userRd <= 1'b0;
        #1;
        d = userRdata;
    endtask

    // Loads the settings, starts the host and waits out its fixed sequence.
    task automatic run_cfg(input logic [7:0] code, input logic [15:0] fout, input logic [7:0] k);
        uwr(4'h1, code);
        uwr(4'h2, fout[7:0]);
        uwr(4'h3, fout[15:8]);
        uwr(4'h4, k);
        uwr(4'h0, 8'h01);
        repeat (12) @(posedge clk);
    endtask

    // Judges a successful set-up against the expected transport settings.
    task automatic check_link(input int l, input int m, input int f, input int s, input int hd, input int fout,
        input logic [7:0] k);
        logic [7:0] st;
        logic [7:0] lo;
        logic [7:0] mi;
        logic [7:0] hi;
        int rate;
        logic low;
        rate = m * 20 * fout / l;
        low = (rate < 6250);
        urd(4'h5, st);
        chk(24'(st), 24'({2'b00, low, 1'b1, 2'b00, 1'b1, 1'b0}));
        urd(4'h6, lo);
        urd(4'h7, mi);
        urd(4'h8, hi);
        chk({hi, mi, lo}, 24'(rate));
        chk(24'({linkUp, laneCount, convCount, octetsPerFrame, samplesPerConv, highDensity}),
            24'({1'b1, 4'(l), 4'(m), 5'(f), 4'(s), 1'(hd)}));
        chk(24'(frameK), 24'(k));
        chk(24'(lowRateMode), 24'(low));
        chk(24'(serialLaneEnable), 24'((1 << l) - 1));
    endtask

    task automatic test_full_rate();
        run_cfg(8'h91, 16'd625, 8'd32);
        check_link(4, 4, 2, 1, 0, 625, 8'd32);
    endtask

    task automatic test_bad_rate();
        logic [7:0] st;
        run_cfg(8'h01, 16'd700, 8'd32);
        urd(4'h5, st);
        chk(24'(st & 8'h0F), 24'h000006);
        run_cfg(8'h00, 16'd200, 8'd32);
        urd(4'h5, st);
        chk(24'(st & 8'h0F), 24'h000006);
        chk(24'({linkUp, laneCount}), 24'({1'b1, 4'h4}));
    endtask

    task automatic test_bad_k();
        logic [7:0] st;
        run_cfg(8'h0A, 16'd100, 8'd4);
        urd(4'h5, st);
        chk(24'(st & 8'h0F), 24'h00000A);
    endtask

    task automatic test_low_rate();
        run_cfg(8'h0A, 16'd100, 8'd8);
        check_link(1, 2, 4, 1, 0, 100, 8'd8);
    endtask

    task automatic test_min_rate();
        run_cfg(8'hC8, 16'd625, 8'd20);
        check_link(8, 2, 1, 2, 1, 625, 8'd20);
    endtask

    // Pulls reset in mid-run, checks both ends come back clean, then brings a link up again.
    task automatic test_reset_mid();
        logic [7:0] d;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(24'({linkUp, serialLaneEnable, lowRateMode}), 24'h000000);
        urd(4'h5, d);
        chk(24'(d), 24'h000020);
        urd(4'h1, d);
        chk(24'(d), 24'h000001);
        urd(4'h4, d);
        chk(24'(d), 24'h000020);
        test_full_rate();
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(24'({linkUp, serialLaneEnable}), 24'h000000);
        test_full_rate();
        test_bad_rate();
        test_bad_k();
        test_low_rate();
        test_min_rate();
        test_reset_mid();
        complete_run();
    end
endmodule
